// ==== pkg/uef_pkg.sv ====
// Purpose: shared constants for the usb event flag block and its controller
// Assumes: 8-bit special-function register port, 20 MHz clock
// Notes: bit positions match the status and endpoint-0 control layouts
package uef_pkg;
   // register addresses on the special-function port
   localparam logic [7:0] ADDR_STATUS = 8'he8;
   localparam logic [7:0] ADDR_ENABLE = 8'he9;
   localparam logic [7:0] ADDR_EP0 = 8'hea;
   localparam logic [7:0] ADDR_EP12 = 8'heb;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // usb_event_status fields
   localparam int ST_SUSP = 7;
   localparam int ST_RSV = 6;
   localparam int ST_RST = 5;
   localparam int ST_TX0 = 4;
   localparam int ST_RX0 = 3;
   localparam int ST_TX12 = 2;
   localparam int ST_EOP = 1;
   localparam int ST_RES = 0;
   localparam int N_CLR_FLAGS = 5;
   // ep0_control fields
   localparam int C0_TOG = 7;
   localparam int C0_STALL = 6;
   localparam int C0_TXE = 5;
   localparam int C0_RXE = 4;
   localparam int C0_CNT_HI = 3;
   localparam int C0_CNT_LO = 0;
   // usb_event_enable and endpoint-1/2 control fields kept here
   localparam int EN_BUS_RESET_ENABLE = 6;
   localparam int C1_TXE = 5;
   // handshake answer codes
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;
   localparam logic [1:0] HS_DATA = 2'h3;
   // controller status values written by itself
   localparam logic [7:0] SUSP_SET_BYTE = 8'hff;
   localparam logic [7:0] SUSP_CLR_BYTE = 8'h7e;
   // timing
   localparam int CLK_HZ = 20000000;
   localparam int IDLE_MS = 3;
   localparam int IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
   localparam int POLL_CYC = 16;
   // axi4-lite map of the controller
   localparam logic [3:0] AXI_CMD = 4'h0;
   localparam logic [3:0] AXI_STAT = 4'h4;
   localparam logic [3:0] AXI_AUTO = 4'h8;
   localparam int CMD_RD = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== pkg/uef_sfr_if.sv ====
// Purpose: special-function register port between controller and usb block
// Assumes: one shared clock; read data valid one cycle after the strobe
// Notes: wr and rd are single-cycle strobes
`timescale 1ns/100ps
interface uef_sfr_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   modport dev (input addr, input wdata, input wr, input rd, output rdata);
   modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// ==== design/uef_usb_dev.sv ====
// Purpose: usb event flags, endpoint-0 control and handshake choice
// Assumes: serial engine delivers token and detection pulses on mclk_in
// Notes: all flags are sampled on mclk_in while ce_in is high; resume is set only while suspended
`timescale 1ns/100ps

module uef_usb_dev
   import uef_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // register port
   uef_sfr_if.dev sfr,
   // serial engine events
   input wire logic usb_reset_det_in,
   input wire logic eop_det_in,
   input wire logic bus_activity_in,
   input wire logic setup_tok_in,
   input wire logic in_tok_in,
   input wire logic out_tok_in,
   input wire logic [3:0] tok_ep_in,
   input wire logic tx_acked_in,
   input wire logic tx_acked_ep12_in,
   input wire logic rx_acked_in,
   // handshake answer
   output logic hs_valid_out,
   output logic [1:0] hs_code_out,
   output logic data_pid1_out,
   output logic [3:0] tx_count_out,
   // power and reset
   output logic usb_clk_en_out,
   output logic suspended_out,
   output logic int_reset_out
);
   logic susp_q;
   logic rst_f_q;
   logic [N_CLR_FLAGS-1:0] flg_q;
   logic [N_CLR_FLAGS-1:0] flg_set;
   logic tog_q;
   logic stall_q;
   logic tx0_en_q;
   logic rx0_en_q;
   logic [3:0] cnt_q;
   logic bus_reset_enable_q;
   logic tx12_en_q;
   logic [7:0] rdata_q;
   logic [7:0] status_d;
   logic [7:0] ep0_d;
   logic hs_valid_q;
   logic [1:0] hs_code_q;
   logic [1:0] hs_code_d;
   logic int_rst_q;
   logic wr_st;
   logic wr_en;
   logic wr_c0;
   logic wr_c1;
   logic ep0_tok;
   logic ep12_tok;

   always_comb begin
      wr_st = 1'b0;
      wr_en = 1'b0;
      wr_c0 = 1'b0;
      wr_c1 = 1'b0;
      if (sfr.addr == ADDR_STATUS) begin
         wr_st = sfr.wr;
      end else if (sfr.addr == ADDR_ENABLE) begin
         wr_en = sfr.wr;
      end else if (sfr.addr == ADDR_EP0) begin
         wr_c0 = sfr.wr;
      end else if (sfr.addr == ADDR_EP12) begin
         wr_c1 = sfr.wr;
      end
   end

   assign ep0_tok = (tok_ep_in == 4'h0);
   assign ep12_tok = (tok_ep_in == 4'h1) || (tok_ep_in == 4'h2);

   // suspend is the one flag that software writes to either value
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         susp_q <= 1'b0;
      end else if (ce_in && wr_st) begin
         susp_q <= sfr.wdata[ST_SUSP];
      end
   end

   // stays set until system reset; software cannot write it
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rst_f_q <= 1'b0;
      end else if (ce_in && usb_reset_det_in) begin
         rst_f_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         int_rst_q <= 1'b0;
      end else if (ce_in) begin
         int_rst_q <= usb_reset_det_in && bus_reset_enable_q;
      end
   end

   always_comb begin
      flg_set = '0;
      flg_set[ST_TX0] = tx_acked_in && !tx_acked_ep12_in;
      flg_set[ST_RX0] = rx_acked_in;
      flg_set[ST_TX12] = tx_acked_in && tx_acked_ep12_in;
      flg_set[ST_EOP] = eop_det_in;
      flg_set[ST_RES] = bus_activity_in && susp_q;
   end

   // a set in the same cycle as a clearing write wins
   genvar gi;
   generate
      for (gi = 0; gi < N_CLR_FLAGS; gi++) begin : g_flag
         always_ff @(posedge mclk_in) begin
            if (!rst_n_in) begin
               flg_q[gi] <= 1'b0;
            end else if (ce_in) begin
               if (flg_set[gi]) begin
                  flg_q[gi] <= 1'b1;
               end else if (wr_st && !sfr.wdata[gi]) begin
                  flg_q[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         tog_q <= 1'b0;
         tx0_en_q <= 1'b0;
         rx0_en_q <= 1'b0;
         cnt_q <= '0;
      end else if (ce_in && wr_c0) begin
         tog_q <= sfr.wdata[C0_TOG];
         tx0_en_q <= sfr.wdata[C0_TXE];
         rx0_en_q <= sfr.wdata[C0_RXE];
         cnt_q <= sfr.wdata[C0_CNT_HI:C0_CNT_LO];
      end
   end

   // software write wins over a setup clear in the same cycle
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         stall_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_c0) begin
            stall_q <= sfr.wdata[C0_STALL];
         end else if (setup_tok_in && ep0_tok) begin
            stall_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         bus_reset_enable_q <= 1'b0;
         tx12_en_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_en) begin
            bus_reset_enable_q <= sfr.wdata[EN_BUS_RESET_ENABLE];
         end
         if (wr_c1) begin
            tx12_en_q <= sfr.wdata[C1_TXE];
         end
      end
   end

   always_comb begin
      status_d = RST_BYTE;
      status_d[ST_SUSP] = susp_q;
      status_d[ST_RSV] = 1'b0;
      status_d[ST_RST] = rst_f_q;
      status_d[N_CLR_FLAGS-1:0] = flg_q;
      ep0_d = {tog_q, stall_q, tx0_en_q, rx0_en_q, cnt_q};
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rdata_q <= RST_BYTE;
      end else if (ce_in && sfr.rd) begin
         if (sfr.addr == ADDR_STATUS) begin
            rdata_q <= status_d;
         end else if (sfr.addr == ADDR_ENABLE) begin
            rdata_q <= {1'b0, bus_reset_enable_q, 6'h00};
         end else if (sfr.addr == ADDR_EP0) begin
            rdata_q <= ep0_d;
         end else if (sfr.addr == ADDR_EP12) begin
            rdata_q <= {2'h0, tx12_en_q, 5'h00};
         end else begin
            rdata_q <= RST_BYTE;
         end
      end
   end

   // stall outranks nak; tokens to other endpoints get no answer here
   always_comb begin
      hs_code_d = HS_NAK;
      if (in_tok_in && ep0_tok) begin
         if (stall_q) begin
            hs_code_d = HS_STALL;
         end else if (!tx0_en_q || flg_q[ST_TX0]) begin
            hs_code_d = HS_NAK;
         end else begin
            hs_code_d = HS_DATA;
         end
      end else if (out_tok_in && ep0_tok) begin
         if (stall_q) begin
            hs_code_d = HS_STALL;
         end else if (!rx0_en_q || flg_q[ST_RX0]) begin
            hs_code_d = HS_NAK;
         end else begin
            hs_code_d = HS_ACK;
         end
      end else if (in_tok_in && ep12_tok) begin
         if (!tx12_en_q || flg_q[ST_TX12]) begin
            hs_code_d = HS_NAK;
         end else begin
            hs_code_d = HS_DATA;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         hs_valid_q <= 1'b0;
         hs_code_q <= HS_NAK;
      end else if (ce_in) begin
         hs_valid_q <= (in_tok_in && (ep0_tok || ep12_tok))
            || (out_tok_in && ep0_tok);
         hs_code_q <= hs_code_d;
      end
   end

   assign sfr.rdata = rdata_q;
   assign hs_valid_out = hs_valid_q;
   assign hs_code_out = hs_code_q;
   assign data_pid1_out = tog_q;
   assign tx_count_out = cnt_q;
   assign usb_clk_en_out = !susp_q;
   assign suspended_out = susp_q;
   assign int_reset_out = int_rst_q;
endmodule

// ==== design/uef_usb_ctl.sv ====
// Purpose: controller that services the usb block for software
// Assumes: software issues register orders over axi4-lite
// Notes: optional automatic suspend entry and resume service
`timescale 1ns/100ps
module uef_usb_ctl
   import uef_pkg::*;
#(
   parameter int IDLE_CYCLES = IDLE_CYC
)
(
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // register port
   uef_sfr_if.ctl sfr,
   // bus idle level from the line monitor
   input wire logic bus_idle_in,
   // axi4-lite slave
   input wire logic [3:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [3:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h1, S_WR = 4'h2, S_RD = 4'h4, S_CAP = 4'h8
   } uef_st_t;
   uef_st_t st_q;
   logic have_aw_q, have_w_q, bvalid_q, rvalid_q;
   logic [3:0] awaddr_q, wstrb_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0] bresp_q, rresp_q;
   logic cmd_pend_q, auto_q, auto_op_q, susp_q;
   logic [16:0] cmd_q;
   logic [7:0] addr_q, wbyte_q, last_q;
   logic [31:0] idle_cnt_q;
   logic [4:0] poll_q;
   logic wr_go;

   assign wr_go = have_aw_q && have_w_q && !bvalid_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (ce_in) begin
         if (awvalid_in && awready_out) begin
            have_aw_q <= 1'b1;
            awaddr_q <= awaddr_in;
         end
         if (wvalid_in && wready_out) begin
            have_w_q <= 1'b1;
            wdata_q <= wdata_in;
            wstrb_q <= wstrb_in;
         end
         if (wr_go) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == AXI_CMD || awaddr_q == AXI_AUTO) ?
               RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && bready_in) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // order register: ignored while an order is still pending
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cmd_pend_q <= 1'b0;
         cmd_q <= '0;
         auto_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_go && awaddr_q == AXI_CMD && !cmd_pend_q
               && wstrb_q == 4'hf) begin
            cmd_pend_q <= 1'b1;
            cmd_q <= wdata_q[16:0];
         end else if (st_q == S_IDLE && cmd_pend_q) begin
            cmd_pend_q <= 1'b0;
         end
         if (wr_go && awaddr_q == AXI_AUTO) begin
            auto_q <= wdata_q[0];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ce_in) begin
         if (arvalid_in && arready_out) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            if (araddr_in == AXI_STAT) begin
               rdata_q <= {15'h0000, susp_q, last_q, 7'h00,
                  cmd_pend_q || st_q != S_IDLE};
            end else if (araddr_in == AXI_AUTO) begin
               rdata_q <= {31'h00000000, auto_q};
            end else begin
               rdata_q <= '0;
               rresp_q <= RESP_SLVERR;
            end
         end else if (rvalid_q && rready_in) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // idle time and resume poll timers for the automatic service
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         idle_cnt_q <= '0;
         poll_q <= '0;
      end else if (ce_in) begin
         idle_cnt_q <= (bus_idle_in && !susp_q) ? idle_cnt_q + 32'd1 : '0;
         poll_q <= (poll_q == 5'(POLL_CYC)) ? '0 : poll_q + 5'd1;
      end
   end

   // software orders take priority over the automatic service
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st_q <= S_IDLE;
         addr_q <= RST_BYTE;
         wbyte_q <= RST_BYTE;
         last_q <= RST_BYTE;
         auto_op_q <= 1'b0;
         susp_q <= 1'b0;
      end else if (ce_in) begin
         case (st_q)
            S_IDLE: begin
               auto_op_q <= 1'b0;
               if (cmd_pend_q) begin
                  addr_q <= cmd_q[15:8];
                  wbyte_q <= cmd_q[7:0];
                  st_q <= cmd_q[CMD_RD] ? S_RD : S_WR;
               end else if (auto_q && !susp_q
                     && idle_cnt_q >= 32'(IDLE_CYCLES)) begin
                  addr_q <= ADDR_STATUS;
                  wbyte_q <= SUSP_SET_BYTE;
                  susp_q <= 1'b1;
                  st_q <= S_WR;
               end else if (auto_q && susp_q && poll_q == '0) begin
                  addr_q <= ADDR_STATUS;
                  auto_op_q <= 1'b1;
                  st_q <= S_RD;
               end
            end
            S_WR: begin
               if (addr_q == ADDR_STATUS && !wbyte_q[ST_SUSP]) begin
                  susp_q <= 1'b0;
               end
               st_q <= S_IDLE;
            end
            S_RD: st_q <= S_CAP;
            S_CAP: begin
               last_q <= sfr.rdata;
               if (auto_op_q && sfr.rdata[ST_RES]) begin
                  wbyte_q <= SUSP_CLR_BYTE;
                  st_q <= S_WR;
               end else begin
                  st_q <= S_IDLE;
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   assign sfr.addr = addr_q;
   assign sfr.wdata = wbyte_q;
   assign sfr.wr = ce_in && st_q == S_WR;
   assign sfr.rd = ce_in && st_q == S_RD;
   assign awready_out = !have_aw_q && !bvalid_q;
   assign wready_out = !have_w_q && !bvalid_q;
   assign bvalid_out = bvalid_q;
   assign bresp_out = bresp_q;
   assign arready_out = !rvalid_q;
   assign rvalid_out = rvalid_q;
   assign rdata_out = rdata_q;
   assign rresp_out = rresp_q;
endmodule

// ==== verif/uef_chk_sva.sv ====
// Purpose: concurrent checks on the usb event flag link
// Assumes: one clock domain, synchronous active-low reset
// Notes: sees the register port plus the device token pins
`timescale 1ns/100ps
module uef_chk_sva
   import uef_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // register port
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   // engine events
   input wire logic in_tok_in,
   input wire logic out_tok_in,
   input wire logic [3:0] tok_ep_in,
   input wire logic tx_acked_in,
   input wire logic tx_acked_ep12_in,
   input wire logic rx_acked_in,
   input wire logic usb_reset_det_in,
   // device outputs
   input wire logic hs_valid_out,
   input wire logic [1:0] hs_code_out,
   input wire logic data_pid1_out,
   input wire logic [3:0] tx_count_out,
   input wire logic usb_clk_en_out,
   input wire logic suspended_out,
   input wire logic int_reset_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   logic st_wr;
   logic c0_wr;
   // a clear in the same cycle would blur the flag, so it is excluded
   assign st_wr = sfr_wr_in && ce_in && sfr_addr_in == ADDR_STATUS;
   assign c0_wr = sfr_wr_in && ce_in && sfr_addr_in == ADDR_EP0;
   chk_tx0_nak: assert property (
      tx_acked_in && !tx_acked_ep12_in && !st_wr ##1
      in_tok_in && tok_ep_in == 4'h0 && !st_wr |=>
      hs_valid_out && hs_code_out != HS_DATA)
      else $error("ep0 in sent data while done flag set");
   chk_rx0_nak: assert property (
      rx_acked_in && !st_wr ##1
      out_tok_in && tok_ep_in == 4'h0 && !st_wr |=>
      hs_valid_out && hs_code_out != HS_ACK)
      else $error("ep0 out accepted while done flag set");
   chk_tx12_nak: assert property (
      tx_acked_in && tx_acked_ep12_in && !st_wr ##1 in_tok_in &&
      (tok_ep_in == 4'h1 || tok_ep_in == 4'h2) && !st_wr |=>
      hs_valid_out && hs_code_out != HS_DATA)
      else $error("ep1/2 in sent data while done flag set");
   chk_int_rst_src: assert property (
      int_reset_out |-> $past(usb_reset_det_in))
      else $error("internal reset without bus reset");
   chk_susp_write: assert property (
      st_wr |=> suspended_out == $past(sfr_wdata_in[ST_SUSP]))
      else $error("suspend state does not follow write");
   chk_clk_stop: assert property (
      usb_clk_en_out != suspended_out)
      else $error("usb clock enable disagrees with suspend");
   chk_ep0_write: assert property (
      c0_wr |=> {data_pid1_out, tx_count_out} ==
      {$past(sfr_wdata_in[C0_TOG]),
      $past(sfr_wdata_in[C0_CNT_HI:C0_CNT_LO])})
      else $error("ep0 control fields misplaced");
   chk_toggle_sw: assert property (
      $changed(data_pid1_out) |-> $past(c0_wr))
      else $error("data toggle moved without a write");
   cov_tx0_nak: cover property (tx_acked_in ##1 in_tok_in);
   cov_int_rst: cover property (int_reset_out);
   cov_susp: cover property ($rose(suspended_out));
endmodule

// ==== verif/tb.sv ====
// Purpose: drives controller over axi4-lite and device engine pins
// Assumes: controller and device joined by one register interface
// Notes: short idle count keeps the auto suspend test brief
`timescale 1ns/100ps
module tb
   import uef_pkg::*;
;
   localparam int IDLE_T = 20;
   logic mclk_in, rst_n_in, ce_in, bus_idle_in;
   logic usb_reset_det_in, eop_det_in, bus_activity_in, setup_tok_in;
   logic in_tok_in, out_tok_in, tx_acked_in, tx_acked_ep12_in;
   logic rx_acked_in, awvalid_in, wvalid_in, bready_in;
   logic arvalid_in, rready_in;
   logic [3:0] tok_ep_in, awaddr_in, wstrb_in, araddr_in, tx_count_out;
   logic [31:0] wdata_in, rdata_out, r;
   logic hs_valid_out, data_pid1_out, usb_clk_en_out, suspended_out;
   logic int_reset_out, awready_out, wready_out, bvalid_out;
   logic arready_out, rvalid_out;
   logic [1:0] hs_code_out, bresp_out, rresp_out, rs;
   logic [6:0] ev;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   uef_sfr_if sfr();
   assign {rx_acked_in, tx_acked_ep12_in, tx_acked_in, setup_tok_in,
      bus_activity_in, eop_det_in, usb_reset_det_in} = ev;
   uef_usb_dev uef_usb_dev_inst (.*);
   uef_usb_ctl #(.IDLE_CYCLES(IDLE_T)) uef_usb_ctl_inst (.*);
   uef_chk_sva uef_chk_sva_inst (.sfr_addr_in(sfr.addr),
      .sfr_wdata_in(sfr.wdata), .sfr_wr_in(sfr.wr), .*);
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   task finish_test();
      if (fail_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // runaway guard, far above the expected run of under a thousand cycles
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task axi_wr(input logic [3:0] a, input logic [31:0] d);
      logic ad, wd, bd;
      @(posedge mclk_in);
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      bd = 1'b0;
      // ready is sampled mid-cycle, where it has settled
      while (!(ad && wd)) begin
         @(negedge mclk_in);
         ad = ad || awready_out;
         wd = wd || wready_out;
         @(posedge mclk_in);
         awvalid_in <= !ad;
         wvalid_in <= !wd;
      end
      while (!bd) begin
         @(negedge mclk_in);
         bd = bvalid_out;
         rs = bresp_out;
         @(posedge mclk_in);
      end
      bready_in <= 1'b0;
   endtask
   task axi_rd(input logic [3:0] a);
      logic ad, dn;
      @(posedge mclk_in);
      araddr_in <= a;
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      ad = 1'b0;
      dn = 1'b0;
      while (!ad) begin
         @(negedge mclk_in);
         ad = arready_out;
         @(posedge mclk_in);
         arvalid_in <= !ad;
      end
      while (!dn) begin
         @(negedge mclk_in);
         dn = rvalid_out;
         r = rdata_out;
         rs = rresp_out;
         @(posedge mclk_in);
      end
      rready_in <= 1'b0;
   endtask
   // order through the controller, then wait until it is idle
   task sfr_op(input logic rdn, input logic [7:0] a, input logic [7:0] d);
      axi_wr(AXI_CMD, {15'h0, rdn, a, d});
      repeat (4) @(posedge mclk_in);
      do axi_rd(AXI_STAT); while (r[0]);
   endtask
   task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      sfr_op(1'b1, a, 8'h00);
      chk({24'h0, r[15:8] & m}, {24'h0, e});
   endtask
   task pulse(input logic [6:0] m);
      @(posedge mclk_in);
      ev <= m;
      @(posedge mclk_in);
      ev <= 7'h00;
      @(negedge mclk_in);
   endtask
   // events m one cycle ahead of the token, answer judged after it
   task tok(input logic i, input logic [3:0] ep, input logic v,
      input logic [1:0] c, input logic [6:0] m);
      @(posedge mclk_in);
      ev <= m;
      @(posedge mclk_in);
      ev <= 7'h00;
      in_tok_in <= i;
      out_tok_in <= !i;
      tok_ep_in <= ep;
      @(posedge mclk_in);
      in_tok_in <= 1'b0;
      out_tok_in <= 1'b0;
      @(negedge mclk_in);
      chk({31'h0, hs_valid_out}, {31'h0, v});
      if (v) chk({30'h0, hs_code_out}, {30'h0, c});
   endtask
   task t_reset();
      rdc(ADDR_STATUS, 8'hff, RST_BYTE);
      rdc(ADDR_EP0, 8'hff, RST_BYTE);
      axi_rd(4'hc);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      tok(1'b1, 4'h0, 1'b1, HS_NAK, 7'h00);
      tok(1'b0, 4'h0, 1'b1, HS_NAK, 7'h00);
   endtask
   task t_ep0();
      sfr_op(1'b0, ADDR_EP0, 8'hb5);
      rdc(ADDR_EP0, 8'hff, 8'hb5);
      chk({27'h0, data_pid1_out, tx_count_out}, 32'h15);
      tok(1'b1, 4'h0, 1'b1, HS_DATA, 7'h00);
      tok(1'b1, 4'h0, 1'b1, HS_NAK, 7'h10);
      tok(1'b1, 4'h0, 1'b1, HS_NAK, 7'h00);
      rdc(ADDR_STATUS, 8'h10, 8'h10);
      sfr_op(1'b0, ADDR_STATUS, 8'h0f);
      rdc(ADDR_STATUS, 8'hff, 8'h00);
      tok(1'b1, 4'h0, 1'b1, HS_DATA, 7'h00);
      chk({31'h0, data_pid1_out}, 32'h1);
      sfr_op(1'b0, ADDR_EP0, 8'h10);
      tok(1'b1, 4'h0, 1'b1, HS_NAK, 7'h00);
      tok(1'b0, 4'h0, 1'b1, HS_ACK, 7'h00);
      tok(1'b0, 4'h0, 1'b1, HS_NAK, 7'h40);
      rdc(ADDR_STATUS, 8'h08, 8'h08);
      sfr_op(1'b0, ADDR_STATUS, 8'h00);
      tok(1'b0, 4'h0, 1'b1, HS_ACK, 7'h00);
   endtask
   task t_ep12_stall();
      sfr_op(1'b0, ADDR_EP12, 8'h20);
      tok(1'b1, 4'h1, 1'b1, HS_DATA, 7'h00);
      tok(1'b1, 4'h2, 1'b1, HS_NAK, 7'h30);
      rdc(ADDR_STATUS, 8'h1c, 8'h04);
      sfr_op(1'b0, ADDR_STATUS, 8'h00);
      tok(1'b1, 4'h2, 1'b1, HS_DATA, 7'h00);
      sfr_op(1'b0, ADDR_EP0, 8'h70);
      tok(1'b1, 4'h0, 1'b1, HS_STALL, 7'h00);
      tok(1'b0, 4'h0, 1'b1, HS_STALL, 7'h00);
      tok(1'b1, 4'h0, 1'b1, HS_DATA, 7'h08);
      rdc(ADDR_EP0, 8'hff, 8'h30);
   endtask
   task t_flags();
      pulse(7'h02);
      sfr_op(1'b0, ADDR_STATUS, 8'h5f);
      rdc(ADDR_STATUS, 8'h42, 8'h02);
      sfr_op(1'b0, ADDR_STATUS, 8'h1d);
      rdc(ADDR_STATUS, 8'h02, 8'h00);
      pulse(7'h04);
      rdc(ADDR_STATUS, 8'h01, 8'h00);
      sfr_op(1'b0, ADDR_STATUS, 8'h80);
      chk({30'h0, usb_clk_en_out, suspended_out}, 32'h1);
      pulse(7'h04);
      rdc(ADDR_STATUS, 8'h81, 8'h81);
      sfr_op(1'b0, ADDR_STATUS, 8'h00);
      rdc(ADDR_STATUS, 8'h81, 8'h00);
      chk({31'h0, usb_clk_en_out}, 32'h1);
   endtask
   task t_auto();
      int n;
      axi_wr(AXI_AUTO, 32'h1);
      axi_rd(AXI_AUTO);
      chk(r, 32'h1);
      @(posedge mclk_in);
      bus_idle_in <= 1'b1;
      n = 0;
      do begin
         @(negedge mclk_in);
         n++;
      end while (!suspended_out);
      chk({31'h0, (n >= IDLE_T && n <= IDLE_T + 4)}, 32'h1);
      @(posedge mclk_in);
      bus_idle_in <= 1'b0;
      pulse(7'h04);
      do @(negedge mclk_in); while (suspended_out);
      rdc(ADDR_STATUS, 8'h81, 8'h00);
      axi_wr(AXI_AUTO, 32'h0);
   endtask
   // an event seen while the enable is low must leave no trace
   task t_freeze();
      @(posedge mclk_in);
      ce_in <= 1'b0;
      pulse(7'h02);
      @(posedge mclk_in);
      ce_in <= 1'b1;
      rdc(ADDR_STATUS, 8'h02, 8'h00);
   endtask
   task t_busrst();
      sfr_op(1'b0, ADDR_ENABLE, 8'h40);
      pulse(7'h01);
      chk({31'h0, int_reset_out}, 32'h1);
      sfr_op(1'b0, ADDR_STATUS, 8'h00);
      rdc(ADDR_STATUS, 8'h20, 8'h20);
      sfr_op(1'b0, ADDR_ENABLE, 8'h00);
      pulse(7'h01);
      chk({31'h0, int_reset_out}, 32'h0);
      pulse(7'h12);
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      rdc(ADDR_STATUS, 8'h1f, 8'h00);
   endtask
   initial begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      bus_idle_in = 1'b0;
      ev = 7'h00;
      in_tok_in = 1'b0;
      out_tok_in = 1'b0;
      tok_ep_in = 4'h0;
      awaddr_in = 4'h0;
      araddr_in = 4'h0;
      wdata_in = 32'h0;
      wstrb_in = 4'hf;
      awvalid_in = 1'b0;
      wvalid_in = 1'b0;
      bready_in = 1'b0;
      arvalid_in = 1'b0;
      rready_in = 1'b0;
      repeat (8) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_ep0();
      t_ep12_stall();
      t_flags();
      t_freeze();
      t_auto();
      t_busrst();
      finish_test();
   end
endmodule
